// ===== hdl/dmx_exec.sv
// decode and execute of four data-move instructions
// assumes data memory answers reads combinationally in the same cycle
`timescale 1ns/1ps
module dmx_exec
	import dmx_pkg::*;
(
	input  wire logic                        mclk_in,
	input  wire logic                        rst_in,
	input  wire logic                        insn_valid_in,
	input  wire logic [dmx_pkg::INSN_W-1:0]  insn_in,
	input  wire logic [dmx_pkg::DATA_W-1:0]  rd_data_in,
	output logic                             insn_taken_out,
	output logic                             rd_en_out,
	output logic [dmx_pkg::ADDR_W-1:0]       rd_addr_out,
	output logic                             wr_en_out,
	output logic [dmx_pkg::ADDR_W-1:0]       wr_addr_out,
	output logic [dmx_pkg::DATA_W-1:0]       wr_data_out,
	output logic [dmx_pkg::DATA_W-1:0]       acc_out,
	output logic [dmx_pkg::DATA_W-1:0]       bank_out,
	output logic                             bad_dest_out
);
	import dmx_pkg::*;

	dmx_state_type state_reg, state_next;
	logic [7:0]  acc_reg, acc_next, bank_reg, bank_next, hold_reg, hold_next;
	logic        rd_en_reg, wr_en_reg, wr_en_next, taken_reg, bad_reg, bad_next;
	logic [11:0] rd_addr_reg, wr_addr_reg, wr_addr_next;
	logic [7:0]  wr_data_reg, wr_data_next;
	logic [11:0] store_addr;

	// prefix match shared by both words of a move
	function automatic logic prefix_is(input logic [15:0] word, input logic [3:0] prefix);
		prefix_is = (word[15:12] == prefix);
	endfunction

	// opcode decode
	wire in_exec   = (state_reg == ST_EXEC);
	wire in_second = (state_reg == ST_SECOND);
	wire is_move   = in_exec & insn_valid_in & prefix_is(insn_in, OP_MOVE_SRC);
	wire is_bank   = in_exec & insn_valid_in & (insn_in[15:8] == OP_LOAD_BANK);
	wire is_lit    = in_exec & insn_valid_in & (insn_in[15:8] == OP_LOAD_ACC);
	wire is_store  = in_exec & insn_valid_in & (insn_in[15:9] == OP_STORE_ACC);
	wire second_ok = in_second & insn_valid_in & prefix_is(insn_in, OP_MOVE_DST);
	wire [11:0] dst = insn_in[11:0];
	wire dst_bad = (dst == PCL_ADDR) | (dst == RETURN_TOP_LOW_BYTE_ADDR) | (dst == RETURN_TOP_HIGH_BYTE_ADDR) | (dst == RETURN_TOP_UPPER_BYTE_ADDR);
	// source read happens combinationally in the first move cycle
	wire        src_rd   = is_move;
	wire [11:0] src_addr = insn_in[11:0];
	// the working register lives in data space, so read its copy directly
	wire [7:0]  src_byte = (src_addr == ACC_ADDR) ? acc_reg : rd_data_in;

	dmx_addr_form u_addr (
		.file_in   (insn_in[7:0]),
		.access_in (insn_in[8]),
		.bank_in   (bank_reg),
		.addr_out  (store_addr)
	);

	// next-state and write selection
	always_comb begin
		state_next   = state_reg;
		acc_next     = acc_reg;
		bank_next    = bank_reg;
		hold_next    = hold_reg;
		wr_en_next   = 1'b0;
		wr_addr_next = wr_addr_reg;
		wr_data_next = wr_data_reg;
		bad_next     = 1'b0;
		unique case (state_reg)
			ST_EXEC: begin
				if (is_move) begin
					hold_next  = src_byte;
					state_next = ST_SECOND;
				end
				if (is_bank) begin
					bank_next = insn_in[7:0];
				end
				if (is_lit) begin
					acc_next = insn_in[7:0];
				end
				if (is_store) begin
					wr_en_next   = (store_addr != ACC_ADDR);
					wr_addr_next = store_addr;
					wr_data_next = acc_reg;
				end
			end
			ST_SECOND: begin
				if (insn_valid_in) begin
					state_next = ST_EXEC;
				end
				if (second_ok) begin
					bad_next = dst_bad;
					if (dst == ACC_ADDR) begin
						acc_next = hold_reg;
					end else if (!dst_bad) begin
						wr_en_next   = 1'b1;
						wr_addr_next = dst;
						wr_data_next = hold_reg;
					end
				end
			end
		endcase
	end

	// state and outputs; the flags kept here are taken, read, write and the one-cycle bad-destination flag
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state_reg   <= ST_EXEC;
			acc_reg     <= ACC_RST;
			bank_reg    <= BANK_RST;
			hold_reg    <= 8'h00;
			rd_en_reg   <= 1'b0;
			rd_addr_reg <= 12'h000;
			wr_en_reg   <= 1'b0;
			wr_addr_reg <= 12'h000;
			wr_data_reg <= 8'h00;
			taken_reg   <= 1'b0;
			bad_reg     <= 1'b0;
		end else begin
			state_reg   <= state_next;
			acc_reg     <= acc_next;
			bank_reg    <= bank_next;
			hold_reg    <= hold_next;
			rd_en_reg   <= src_rd;
			rd_addr_reg <= src_addr;
			wr_en_reg   <= wr_en_next;
			wr_addr_reg <= wr_addr_next;
			wr_data_reg <= wr_data_next;
			taken_reg   <= insn_valid_in;
			bad_reg     <= bad_next;
		end
	end

	assign insn_taken_out = taken_reg;
	assign rd_en_out      = rd_en_reg;
	assign rd_addr_out    = rd_addr_reg;
	assign wr_en_out      = wr_en_reg;
	assign wr_addr_out    = wr_addr_reg;
	assign wr_data_out    = wr_data_reg;
	assign acc_out        = acc_reg;
	assign bank_out       = bank_reg;
	assign bad_dest_out   = bad_reg;

	// move shapes shared by the checks below; each spans both words
	sequence s_move_pair;
		is_move ##1 second_ok && !dst_bad && dst != ACC_ADDR;
	endsequence
	sequence s_move_from_mem;
		is_move && src_addr != ACC_ADDR ##1 second_ok && !dst_bad && dst != ACC_ADDR;
	endsequence
	sequence s_move_to_acc;
		is_move && src_addr != ACC_ADDR ##1 second_ok && dst == ACC_ADDR;
	endsequence
	sequence s_move_cut;
		is_move ##1 insn_valid_in && !second_ok;
	endsequence

	// move reaches destination exactly one cycle after second word
	a_move_write: assert property (@(posedge mclk_in) disable iff (rst_in)
		s_move_pair |=> wr_en_out && wr_addr_out == $past(dst)) else $error("move write missing");
	a_move_data: assert property (@(posedge mclk_in) disable iff (rst_in)
		s_move_from_mem |=> wr_data_out == $past(rd_data_in, 2)) else $error("move data wrong");
	a_move_pass: assert property (@(posedge mclk_in) disable iff (rst_in)
		s_move_pair |=> !bad_dest_out) else $error("legal dest flagged");
	// the accumulator target is written inside the core, never on the bus
	a_move_acc: assert property (@(posedge mclk_in) disable iff (rst_in)
		s_move_to_acc |=> !wr_en_out && acc_out == $past(rd_data_in, 2)) else $error("move to acc wrong");
	// a foreign second word ends the move with nothing written
	a_move_cut: assert property (@(posedge mclk_in) disable iff (rst_in)
		s_move_cut |=> !wr_en_out && !bad_dest_out && state_reg == ST_EXEC) else $error("cut move wrote");
	a_move_second: assert property (@(posedge mclk_in) disable iff (rst_in)
		is_move |=> state_reg == ST_SECOND) else $error("move not two cycles");

	// the source read is recorded once, never for the second word
	a_move_read: assert property (@(posedge mclk_in) disable iff (rst_in)
		is_move |=> rd_en_out && rd_addr_out == $past(insn_in[11:0])) else $error("move read record wrong");
	a_second_noread: assert property (@(posedge mclk_in) disable iff (rst_in)
		in_second |=> !rd_en_out) else $error("read during second word");

	// single-word loads land one cycle after the word is taken
	a_bank_load: assert property (@(posedge mclk_in) disable iff (rst_in)
		is_bank |=> bank_out == $past(insn_in[7:0]) && !wr_en_out) else $error("bank load wrong");
	a_bank_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
		!is_bank |=> $stable(bank_out)) else $error("bank changed without load");
	a_lit_load: assert property (@(posedge mclk_in) disable iff (rst_in)
		is_lit |=> acc_out == $past(insn_in[7:0]) && !wr_en_out) else $error("literal load wrong");
	a_acc_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
		!is_lit && !(second_ok && dst == ACC_ADDR) |=> $stable(acc_out)) else $error("acc changed without load");
	a_word_taken: assert property (@(posedge mclk_in) disable iff (rst_in)
		insn_valid_in |=> insn_taken_out) else $error("word not taken");
	a_word_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
		!insn_valid_in |=> !insn_taken_out) else $error("idle cycle taken");

	// store: data, banked and access-bank addresses
	a_store_data: assert property (@(posedge mclk_in) disable iff (rst_in)
		is_store && store_addr != ACC_ADDR |=> wr_en_out && wr_data_out == $past(acc_reg)) else $error("store wrong");
	a_store_bank: assert property (@(posedge mclk_in) disable iff (rst_in)
		is_store && insn_in[8] && store_addr != ACC_ADDR
		|=> wr_addr_out == {$past(bank_reg[3:0]), $past(insn_in[7:0])}) else $error("banked address wrong");
	a_store_access: assert property (@(posedge mclk_in) disable iff (rst_in)
		is_store && !insn_in[8] && insn_in[7] == 1'b0 |=> wr_addr_out[11:8] == 4'h0) else $error("access bank wrong");
	a_access_high: assert property (@(posedge mclk_in) disable iff (rst_in)
		is_store && !insn_in[8] && insn_in[7] && insn_in[7:0] != ACC_ADDR[7:0]
		|=> wr_en_out && wr_addr_out == {BANK_HIGH_SFR, $past(insn_in[7:0])}) else $error("access high wrong");
	// the accumulator already holds the value, so no bus write is made
	a_store_skip: assert property (@(posedge mclk_in) disable iff (rst_in)
		is_store && !insn_in[8] && insn_in[7:0] == ACC_ADDR[7:0] |=> !wr_en_out) else $error("store to acc on bus");

	// forbidden destinations are dropped and flagged for one cycle
	a_bad_dest: assert property (@(posedge mclk_in) disable iff (rst_in)
		second_ok && dst_bad |=> !wr_en_out && bad_dest_out) else $error("forbidden dest written");
	a_bad_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
		bad_dest_out |=> !bad_dest_out) else $error("bad dest flag held");
endmodule

// ===== shared/dmx_pkg.sv
// constants for the data-move execute block
// assumes 16-bit instruction words and a 12-bit data address space
package dmx_pkg;
	localparam int DATA_W   = 8;
	localparam int ADDR_W   = 12;
	localparam int INSN_W   = 16;
	// opcode prefixes and patterns
	localparam logic [3:0] OP_MOVE_SRC   = 4'hc;
	localparam logic [3:0] OP_MOVE_DST   = 4'hf;
	localparam logic [7:0] OP_LOAD_BANK  = 8'h01;
	localparam logic [7:0] OP_LOAD_ACC   = 8'h0e;
	localparam logic [6:0] OP_STORE_ACC  = 7'h37;
	// access bank split, working register and forbidden destination locations
	localparam logic [7:0] ACCESS_SPLIT  = 8'h80;
	localparam logic [3:0] BANK_HIGH_SFR = 4'hf;
	localparam logic [11:0] ACC_ADDR     = 12'hfe8;
	localparam logic [11:0] PCL_ADDR     = 12'hff9;
	localparam logic [11:0] RETURN_TOP_LOW_BYTE_ADDR    = 12'hffd;
	localparam logic [11:0] RETURN_TOP_HIGH_BYTE_ADDR    = 12'hffe;
	localparam logic [11:0] RETURN_TOP_UPPER_BYTE_ADDR    = 12'hfff;
	// reset values
	localparam logic [7:0] BANK_RST = 8'h00;
	localparam logic [7:0] ACC_RST  = 8'h00;
	typedef enum logic [1:0] {
		ST_EXEC   = 2'b01,
		ST_SECOND = 2'b10
	} dmx_state_type;
endpackage

// ===== hdl/dmx_addr_form.sv
// banked address former for single-word file operations
// assumes combinational use inside the core clock domain
`timescale 1ns/1ps
module dmx_addr_form
	import dmx_pkg::*;
(
	input  wire logic [7:0]        file_in,
	input  wire logic              access_in,
	input  wire logic [7:0]        bank_in,
	output logic [dmx_pkg::ADDR_W-1:0] addr_out
);
	// access bank: low half in bank 0, high half in special registers
	wire [11:0] access_addr = (file_in < ACCESS_SPLIT) ? {4'h0, file_in} : {BANK_HIGH_SFR, file_in};
	assign addr_out = access_in ? {bank_in[3:0], file_in} : access_addr;
endmodule

// ===== verif/dmx_mem_model.sv
// data memory model facing the execute block
// assumes reads answer combinationally from the word's address field
`timescale 1ns/1ps
module dmx_mem_model
	import dmx_pkg::*;
(
	input  wire logic                       mclk_in,
	input  wire logic [dmx_pkg::INSN_W-1:0] insn_in,
	input  wire logic                       wr_en_in,
	input  wire logic [dmx_pkg::ADDR_W-1:0] wr_addr_in,
	input  wire logic [dmx_pkg::DATA_W-1:0] wr_data_in,
	output logic      [dmx_pkg::DATA_W-1:0] rd_data_out
);
	logic [7:0] mem [0:4095];
	// seeded so the bench can predict every byte
	initial begin
		for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h5a;
	end
	// flat 12-bit reach, no banking
	assign rd_data_out = mem[insn_in[11:0]];
	// write lands on the edge of the pulse
	always @(posedge mclk_in) begin
		if (wr_en_in) mem[wr_addr_in] <= wr_data_in;
	end
endmodule

// ===== verif/tb.sv
// self-checking bench for the data-move execute block
// assumes the memory model answers reads in the same cycle
`timescale 1ns/1ps
module tb;
	import dmx_pkg::*;
	logic        mclk_in = 0, rst_in = 1, insn_valid_in = 0;
	logic [15:0] insn_in = 16'h0000;
	logic [7:0]  rd_data_in, acc_out, bank_out, wr_data_out;
	logic [11:0] rd_addr_out, wr_addr_out;
	logic        insn_taken_out, rd_en_out, wr_en_out, bad_dest_out;
	int          err_count = 0, checks_done = 0;
	always #20 mclk_in = ~mclk_in;
	dmx_exec i_dmx_exec (.mclk_in(mclk_in), .rst_in(rst_in), .insn_valid_in(insn_valid_in),
		.insn_in(insn_in), .rd_data_in(rd_data_in), .insn_taken_out(insn_taken_out),
		.rd_en_out(rd_en_out), .rd_addr_out(rd_addr_out), .wr_en_out(wr_en_out),
		.wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out), .acc_out(acc_out),
		.bank_out(bank_out), .bad_dest_out(bad_dest_out));
	dmx_mem_model i_dmx_mem_model (.mclk_in(mclk_in), .insn_in(insn_in), .wr_en_in(wr_en_out),
		.wr_addr_in(wr_addr_out), .wr_data_in(wr_data_out), .rd_data_out(rd_data_in));
	task automatic chk_val(string n, logic [11:0] e, logic [11:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_bit(string n, logic e, logic g);
		chk_val(n, {11'h000, e}, {11'h000, g});
	endtask
	// present a word at the edge; return once it has settled
	task automatic put(logic [15:0] w);
		@(posedge mclk_in);
		insn_in <= w;
		insn_valid_in <= 1'b1;
		#1;
	endtask
	task automatic idle();
		@(posedge mclk_in);
		insn_valid_in <= 1'b0;
		#1;
	endtask
	// back-to-back literal and bank loads
	task automatic t_loads();
		put(16'h0e5a);
		put(16'h0103);
		chk_val("acc", 12'h05a, {4'h0, acc_out});
		idle();
		chk_val("bank", 12'h003, {4'h0, bank_out});
	endtask
	task automatic t_move(logic [11:0] s, logic [11:0] d);
		put({OP_MOVE_SRC, s});
		put({OP_MOVE_DST, d});
		chk_bit("rd_en", 1'b1, rd_en_out);
		chk_val("rd_addr", s, rd_addr_out);
		chk_bit("early_wr", 1'b0, wr_en_out);
		idle();
		chk_bit("wr_en", 1'b1, wr_en_out);
		chk_bit("no_rd", 1'b0, rd_en_out);
		chk_val("wr_addr", d, wr_addr_out);
		chk_val("wr_data", {4'h0, s[7:0] ^ 8'h5a}, {4'h0, wr_data_out});
	endtask
	// working register as move destination, then as source
	task automatic t_move_acc();
		put({OP_MOVE_SRC, 12'h123});
		put({OP_MOVE_DST, ACC_ADDR});
		idle();
		chk_val("acc_mv", 12'h079, {4'h0, acc_out});
		put({OP_MOVE_SRC, ACC_ADDR});
		put({OP_MOVE_DST, 12'h456});
		idle();
		chk_val("from_acc", 12'h079, {4'h0, wr_data_out});
	endtask
	task automatic t_bad_dest();
		logic [11:0] fb [4] = '{PCL_ADDR, RETURN_TOP_LOW_BYTE_ADDR, RETURN_TOP_HIGH_BYTE_ADDR, RETURN_TOP_UPPER_BYTE_ADDR};
		foreach (fb[i]) begin
			t_bad_one(fb[i]);
		end
	endtask
	task automatic t_bad_one(logic [11:0] d);
		put({OP_MOVE_SRC, 12'h020});
		put({OP_MOVE_DST, d});
		idle();
		chk_bit("bad_dest", 1'b1, bad_dest_out);
		chk_bit("dropped", 1'b0, wr_en_out);
	endtask
	// access bank low, access bank high, then banked
	task automatic t_store();
		logic [15:0] w [3] = '{16'h6e10, 16'h6e90, 16'h6f10};
		logic [11:0] a [3] = '{12'h010, 12'hf90, 12'h210};
		put(16'h0e77);
		put(16'h0102);
		foreach (w[i]) begin
			put(w[i]);
			idle();
			chk_bit("st_en", 1'b1, wr_en_out);
			chk_val("st_addr", a[i], wr_addr_out);
			chk_val("st_data", 12'h077, {4'h0, wr_data_out});
		end
	endtask
	// a move cut short by a foreign word, then a store aimed at the accumulator
	task automatic t_odd();
		put({OP_MOVE_SRC, 12'h020});
		put(16'h0e11);
		idle();
		chk_bit("cut_wr", 1'b0, wr_en_out);
		chk_bit("cut_bad", 1'b0, bad_dest_out);
		chk_val("cut_acc", 12'h077, {4'h0, acc_out});
		put(16'h6ee8);
		idle();
		chk_bit("st_acc", 1'b0, wr_en_out);
		chk_bit("taken", 1'b1, insn_taken_out);
		idle();
		chk_bit("untaken", 1'b0, insn_taken_out);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_loads();
		t_move(12'h000, 12'hffc);
		t_move(12'hfff, 12'h001);
		t_move_acc();
		t_bad_dest();
		t_store();
		t_odd();
		// no scenario moves into interrupt settings
		print_verdict();
	end
	// tests need under a hundred cycles; this is far beyond
	initial begin
		#100000;
		err_count++;
		print_verdict();
	end
endmodule
